// [rtl/gpc_pkg.sv]
package gpc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] PIN45_PAD_CONTROL_OFS = 12'h0C0;
  localparam logic [11:0] PIN46_PAD_CONTROL_OFS = 12'h0C4;
  localparam logic [11:0] PIN47_PAD_CONTROL_OFS = 12'h0C8;
  localparam logic [11:0] OUTPUT_LEVELS_LOW_OFS = 12'h100;
  localparam logic [11:0] OUTPUT_LEVELS_HIGH_OFS = 12'h104;

  // ****************************************************************
  // pad control fields
  // ****************************************************************
  localparam int DRIVE_LSB = 12;
  localparam int DRIVE_MSB = 14;
  localparam int PULLDOWN_BIT = 9;
  localparam int PULLUP_BIT = 8;
  localparam int INPUT_EN_BIT = 7;
  localparam int OUTPUT_EN_BIT = 6;
  localparam int ANALOG_SEL_BIT = 4;
  localparam logic [31:0] PAD_CTL_WMASK = 32'h0000_73D0;
  localparam logic [31:0] PAD_CTL_RESET = 32'h0000_1010;

  // ****************************************************************
  // output data
  // ****************************************************************
  localparam int NUM_CTL_PINS = 3;
  localparam int FIRST_CTL_PIN = 45;
  localparam int NUM_PINS = 52;
  localparam int HIGH_BITS = 20;
  localparam logic [31:0] OUT_LOW_RESET = 32'h0000_0000;
  localparam logic [31:0] OUT_HIGH_WMASK = 32'h000F_FFFF;
  localparam logic [31:0] OUT_HIGH_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] drive_strength_sel;
    logic weak_pulldown_en;
    logic weak_pullup_en;
    logic input_path_en;
    logic output_driver_en;
    logic analog_sel;
  } gpc_pad_t;

endpackage

// [rtl/gpc_reg_if.sv]
`timescale 1ns/100ps

interface gpc_reg_if;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport owner
  (
    input wr_en,
    input wdata,
    output rdata
  );
  modport user
  (
    output wr_en,
    output wdata,
    input rdata
  );
endinterface

// [rtl/gpc_word_reg.sv]
`timescale 1ns/100ps

module gpc_word_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // async reset, active low
  gpc_reg_if.owner bus // write strobe, data, readback
);

  logic [31:0] value_r;
  logic [31:0] value_nxt;

  // unmasked bits are hard zero so reserved bits read back as zero
  assign value_nxt = bus.wr_en ? (bus.wdata & WMASK) : value_r;
  assign bus.rdata = value_r & WMASK;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      value_r <= RESET_VAL;
    else
      value_r <= value_nxt;
  end

endmodule

// [rtl/gpc_top.sv]
// Added by the designer: the APB register port.
`timescale 1ns/100ps

// Behaviour
// - drive strength bits 14:12, reset one
// - bit 9 weak pull-down, reset zero
// - bit 8 weak pull-up, reset zero
// - bit 7 input path, reset zero
// - bit 6 output driver, reset zero
// - bit 4 analog select, reset one
// - 0x100 holds levels, pins 0-31
// - 0x104 bits 19:0, pins 32-51
// - reserved control bits read zero
module gpc_top (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [2:0] pin45_drive_strength_sel, // pad drive level
  output logic [2:0] pin46_drive_strength_sel, // pad drive level
  output logic [2:0] pin47_drive_strength_sel, // pad drive level
  output logic [2:0] weak_pulldown_en, // pins 47..45
  output logic [2:0] weak_pullup_en, // pins 47..45
  output logic [2:0] input_path_en, // pins 47..45
  output logic [2:0] analog_sel, // pins 47..45, 1 = analog
  output logic [51:0] pin_out, // output levels
  output logic [51:0] pin_oe_n // driver enable, low = driving
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  localparam int NREG = 5;

  function automatic logic [NREG-1:0] gpc_decode(input logic [11:0] addr);
    logic [NREG-1:0] sel;
    sel = '0;
    sel[0] = (addr == gpc_pkg::PIN45_PAD_CONTROL_OFS);
    sel[1] = (addr == gpc_pkg::PIN46_PAD_CONTROL_OFS);
    sel[2] = (addr == gpc_pkg::PIN47_PAD_CONTROL_OFS);
    sel[3] = (addr == gpc_pkg::OUTPUT_LEVELS_LOW_OFS);
    sel[4] = (addr == gpc_pkg::OUTPUT_LEVELS_HIGH_OFS);
    return sel;
  endfunction

  wire logic [NREG-1:0] reg_hit;
  wire logic bus_access;
  wire logic bus_write;
  wire logic unmapped;

  assign reg_hit = gpc_decode(paddr);
  assign bus_access = psel & penable;
  assign bus_write = bus_access & pwrite;
  assign unmapped = ~(|reg_hit);

  // zero wait state; unmapped addresses answer with an error, write ignored
  assign pready = 1'b1;
  assign pslverr = bus_access & unmapped;

  // ****************************************************************
  // registers
  // ****************************************************************
  gpc_reg_if ctl_if[gpc_pkg::NUM_CTL_PINS]();
  gpc_reg_if low_if();
  gpc_reg_if high_if();
  gpc_pkg::gpc_pad_t pad [gpc_pkg::NUM_CTL_PINS];
  logic [31:0] ctl_rd [gpc_pkg::NUM_CTL_PINS];

  genvar gi;
  generate
    for (gi = 0; gi < gpc_pkg::NUM_CTL_PINS; gi++)
    begin : g_ctl
      assign ctl_if[gi].wr_en = bus_write & reg_hit[gi];
      assign ctl_if[gi].wdata = pwdata;
      assign ctl_rd[gi] = ctl_if[gi].rdata;
      // reserved bits masked off in the register itself
      gpc_word_reg #(
        .RESET_VAL(gpc_pkg::PAD_CTL_RESET),
        .WMASK(gpc_pkg::PAD_CTL_WMASK)
      ) u_ctl (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bus(ctl_if[gi])
      );
      assign pad[gi].drive_strength_sel =
        ctl_rd[gi][gpc_pkg::DRIVE_MSB:gpc_pkg::DRIVE_LSB];
      assign pad[gi].weak_pulldown_en = ctl_rd[gi][gpc_pkg::PULLDOWN_BIT];
      assign pad[gi].weak_pullup_en = ctl_rd[gi][gpc_pkg::PULLUP_BIT];
      assign pad[gi].input_path_en = ctl_rd[gi][gpc_pkg::INPUT_EN_BIT];
      assign pad[gi].output_driver_en = ctl_rd[gi][gpc_pkg::OUTPUT_EN_BIT];
      assign pad[gi].analog_sel = ctl_rd[gi][gpc_pkg::ANALOG_SEL_BIT];
      assign weak_pulldown_en[gi] = pad[gi].weak_pulldown_en;
      assign weak_pullup_en[gi] = pad[gi].weak_pullup_en;
      assign input_path_en[gi] = pad[gi].input_path_en;
      assign analog_sel[gi] = pad[gi].analog_sel;
    end
  endgenerate

  assign pin45_drive_strength_sel = pad[0].drive_strength_sel;
  assign pin46_drive_strength_sel = pad[1].drive_strength_sel;
  assign pin47_drive_strength_sel = pad[2].drive_strength_sel;

  assign low_if.wr_en = bus_write & reg_hit[3];
  assign low_if.wdata = pwdata;
  gpc_word_reg #(
    .RESET_VAL(gpc_pkg::OUT_LOW_RESET),
    .WMASK(32'hFFFF_FFFF)
  ) u_low (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .bus(low_if)
  );

  assign high_if.wr_en = bus_write & reg_hit[4];
  assign high_if.wdata = pwdata;
  gpc_word_reg #(
    .RESET_VAL(gpc_pkg::OUT_HIGH_RESET),
    .WMASK(gpc_pkg::OUT_HIGH_WMASK)
  ) u_high (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .bus(high_if)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire logic [31:0] rd_mux;
  assign rd_mux = ({32{reg_hit[0]}} & ctl_rd[0])
                | ({32{reg_hit[1]}} & ctl_rd[1])
                | ({32{reg_hit[2]}} & ctl_rd[2])
                | ({32{reg_hit[3]}} & low_if.rdata)
                | ({32{reg_hit[4]}} & high_if.rdata);
  assign prdata = rd_mux;

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // pins without a control register here are owned by logic elsewhere;
  // only their level is produced and the enable stays off
  logic [51:0] oe_n_r;
  logic [51:0] oe_n_nxt;
  logic [51:0] out_r;
  wire logic [51:0] levels;

  assign levels = {high_if.rdata[gpc_pkg::HIGH_BITS-1:0], low_if.rdata};

  always_comb
  begin
    oe_n_nxt = '1;
    for (int i = 0; i < gpc_pkg::NUM_CTL_PINS; i++)
      oe_n_nxt[gpc_pkg::FIRST_CTL_PIN + i] =
        ~(pad[i].output_driver_en & ~pad[i].analog_sel);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_n_r <= '1;
      out_r <= '0;
    end
    else
    begin
      oe_n_r <= oe_n_nxt;
      out_r <= levels;
    end
  end

  assign pin_out = out_r;
  assign pin_oe_n = oe_n_r;

endmodule

// [testbench/gpc_chk_monitor.sv]
`timescale 1ns/100ps
module gpc_chk (
  input wire logic ref_clk, // clock
  input wire logic reset_n, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [2:0] pin45_drive_strength_sel, // pad
  input wire logic [2:0] weak_pulldown_en, // pad
  input wire logic [2:0] weak_pullup_en, // pad
  input wire logic [2:0] input_path_en, // pad
  input wire logic [2:0] analog_sel, // pad
  input wire logic [51:0] pin_out, // pins
  input wire logic [51:0] pin_oe_n // pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  logic [31:0] wd_r;
  logic [31:0] wd2_r;
  // write data delayed to line up with the flopped outputs
  always_ff @(posedge ref_clk)
  begin
    wd_r <= pwdata;
    wd2_r <= wd_r;
  end
  a_pad_reset: assert property ($rose(reset_n) |-> pin45_drive_strength_sel == 3'h1 && &analog_sel)
    else $error("pad reset value wrong");
  a_pull_reset: assert property ($rose(reset_n) |-> {weak_pulldown_en, weak_pullup_en, input_path_en} == 9'h0)
    else $error("pull reset value wrong");
  a_oe_reset: assert property ($rose(reset_n) |-> &pin_oe_n && pin_out == 52'h0)
    else $error("pin reset value wrong");
  a_unmapped_err: assert property (acc && paddr == 12'h0CC |-> pready && pslverr)
    else $error("unmapped access not refused");
  a_ctl_rsvd: assert property (psel && !pwrite && paddr == 12'h0C0 |-> (prdata & 32'hFFFF_8C2F) == 32'h0)
    else $error("reserved control bits set");
  a_high_rsvd: assert property (psel && !pwrite && paddr == 12'h104 |-> prdata[31:20] == 12'h0)
    else $error("reserved data bits set");
  a_drv_write: assert property (acc && pwrite && paddr == 12'h0C0 |=> pin45_drive_strength_sel == wd_r[14:12])
    else $error("drive level not updated");
  a_low_data: assert property (acc && pwrite && paddr == 12'h100 |-> ##2 pin_out[31:0] == wd2_r)
    else $error("low levels not on pins");
  a_oe_digital: assert property ((~pin_oe_n[47:45] & $past(analog_sel)) == 3'h0)
    else $error("analog pin driven");
  a_oe_others: assert property (&pin_oe_n[44:0] && &pin_oe_n[51:48])
    else $error("uncontrolled pin driven");
endmodule
bind gpc_top gpc_chk u_chk (.*);

// [testbench/gpc_pad_model.sv]
`timescale 1ns/100ps
module gpc_pad_model (
  input wire logic ref_clk, // clock
  input wire logic [51:0] pin_out, // levels
  input wire logic [51:0] pin_oe_n, // low = driven
  input wire logic [2:0] weak_pullup_en, // pulls
  input wire logic [2:0] weak_pulldown_en, // pulls
  output logic [2:0] pad // pins 47..45
);
  // a floating pad wanders so a stale level is never trusted
  logic [2:0] float_r = 3'h5;
  always @(posedge ref_clk)
    float_r <= ~float_r;
  always_comb
    for (int i = 0; i < 3; i++)
      pad[i] = !pin_oe_n[45+i] ? pin_out[45+i] : weak_pullup_en[i] ? 1'b1 :
        weak_pulldown_en[i] ? 1'b0 : float_r[i];
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, on;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [2:0] pin45_drive_strength_sel, pin46_drive_strength_sel, pin47_drive_strength_sel;
  logic [2:0] weak_pulldown_en, weak_pullup_en, input_path_en, analog_sel, pad;
  logic [51:0] pin_out, pin_oe_n;
  logic [3:0] cw;
  int fail_count = 0, tests_run = 0, seed = 49787;
  logic [31:0] m [5] = '{32'h0000_1010, 32'h0000_1010, 32'h0000_1010, 32'h0, 32'h0};
  logic [31:0] wm [5] = '{32'h0000_73D0, 32'h0000_73D0, 32'h0000_73D0, 32'hFFFF_FFFF, 32'h000F_FFFF};
  logic [11:0] ofs [5] = '{12'h0C0, 12'h0C4, 12'h0C8, 12'h100, 12'h104};
  wire [8:0] ds = {pin47_drive_strength_sel, pin46_drive_strength_sel, pin45_drive_strength_sel};
  gpc_top dut (.*);
  gpc_pad_model u_pad (.*);
  initial
    forever #12.5 ref_clk = ~ref_clk;
  task chk(input string n, input logic [51:0] got, input logic [51:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // idle cycle at the end so psel is never driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task final_report();
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // register and pin sweep
  // ****************************************
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int it = 0; it < 9; it++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (it > 0)
        begin
          d = $random(seed);
          if (k < 3) d[14:12] = 3'(it - 1 + k);
          if (k < 3 && it[0]) d[4] = 1'b0;
          apb(1'b1, ofs[k], d);
          m[k] = d & wm[k];
        end
        apb(1'b0, ofs[k], 32'h0);
        chk("register", {err, rd}, {1'b0, m[k]});
      end
      apb(1'b1, 12'h0CC, d);
      apb(1'b0, 12'h0CC, 32'h0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      repeat (2) @(posedge ref_clk);
      #1;
      chk("pin_out", pin_out, {m[4][19:0], m[3]});
      for (int i = 0; i < 3; i++)
      begin
        on = m[i][6] & !m[i][4];
        chk("oe_n", pin_oe_n[45+i], !on);
        chk("drive", ds[3*i +: 3], m[i][14:12]);
        cw = {weak_pulldown_en[i], weak_pullup_en[i], input_path_en[i], analog_sel[i]};
        chk("ctl", cw, {m[i][9], m[i][8], m[i][7], m[i][4]});
        if (on | m[i][8] | m[i][9])
          chk("pad", pad[i], on ? m[4][13+i] : m[i][8]);
      end
    end
    final_report();
  end
  initial
  begin
    #50us;
    fail_count++;
    final_report();
  end
endmodule
